// ### src/twrp_pkg.sv
// Package: constants, field layout and frame type for the serial programming port
package twrp_pkg;
  // Frame layout: 28 data bits above a 4-bit address
  localparam int FRAME_W = 32;
  localparam int DATA_W = 28;
  localparam int ADDR_W = 4;
  localparam int NUM_REGS = 16;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } twrp_frame_t;

  // Internal register indices with trigger side effects
  localparam logic [ADDR_W-1:0] REG_MAIN = 4'h0;
  localparam logic [ADDR_W-1:0] REG_FASTLOCK = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SYSTEM = 4'h5;
  // Software reset bit of the system register (frame bit 4 = data bit 0)
  localparam int SRST_BIT = 0;
  // Calibration skip bit inside the main register data field
  localparam int CAL_SKIP_BIT = 17;
  // Fastlock timeout count field inside the fastlock register data field
  localparam int FASTLOCK_TIMEOUT_COUNT_LSB = 12;
  localparam int FASTLOCK_TIMEOUT_COUNT_W = 12;

  // Power-on default of every internal register
  localparam logic [DATA_W-1:0] REG_DEFAULT = 28'h0000000;

  // Soft reset must finish within this time
  localparam int SRST_MAX_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SRST_MAX_CYC = SRST_MAX_NS / CLK_PERIOD_NS;

  // Avalon-MM byte addresses
  localparam int BUS_AW = 8;
  localparam logic [BUS_AW-1:0] OFS_BANK_TOP = 8'h3c;
  localparam logic [BUS_AW-1:0] OFS_CTRL = 8'h40;
  localparam logic [BUS_AW-1:0] OFS_STAT = 8'h44;
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  // Status register fields (sticky, write one to clear)
  localparam int ST_CAL_BIT = 0;
  localparam int ST_FL_BIT = 1;
  localparam int ST_SRST_BIT = 2;
  localparam int ST_FRAME_BIT = 3;
  localparam int ST_W = 4;
  localparam logic [ST_W-1:0] ST_RESET = 4'h0;
  // Idle pin levels {strobe, data, clock}: strobe high, clock low
  localparam logic [2:0] PIN_IDLE = 3'h4;
endpackage

// ### src/twrp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module twrp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0 // Idle level of each pin
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta; // First stage, read only by second stage

  // Both stages reset to the idle levels, so no false edge follows reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // twrp_sync

// ### src/twrp_port.sv
// Three-wire programming port with register bank, triggers and Avalon-MM slave
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/100ps
module twrp_port
  import twrp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk, // Serial clock pin
  input wire logic i_sdata, // Serial data pin
  input wire logic i_load_strobe, // Load strobe pin
  input wire logic [BUS_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_cal_start, // One-cycle calibration start
  output logic o_fastlock_start, // One-cycle fastlock engage
  output logic o_soft_reset // One-cycle soft reset done
);
  logic [2:0] pins_s; // Synchronised pins
  logic sclk_d; // Delayed clock for edge find
  logic strobe_d; // Delayed strobe for edge find
  logic [FRAME_W-1:0] shreg; // Temporary shift register
  logic [DATA_W-1:0] bank [NUM_REGS]; // Internal registers
  logic [31:0] ctrl; // Control register
  logic [ST_W-1:0] stat; // Sticky status
  logic ack; // Bus answer phase

  // Pins pass two flops before any use
  twrp_sync #(.W(3), .RST_VAL(PIN_IDLE)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_load_strobe, i_sdata, i_sclk}),
    .o_sync(pins_s)
  );

  // Decode of pins and frame
  wire sclk_s = pins_s[0];
  wire data_s = pins_s[1];
  wire strobe_s = pins_s[2];
  wire sclk_rise = sclk_s & ~sclk_d;
  wire strobe_rise = strobe_s & ~strobe_d;
  wire shift_en = sclk_rise & ~strobe_s;
  wire twrp_frame_t frame = twrp_frame_t'(shreg);
  wire commit = strobe_rise & ctrl[CTRL_EN_BIT];
  wire srst_hit = commit && frame.addr == REG_SYSTEM && frame.data[SRST_BIT];
  wire main_hit = commit && frame.addr == REG_MAIN;
  // Fastlock uses register 4 as it stood before this commit
  wire [FASTLOCK_TIMEOUT_COUNT_W-1:0] fastlock_timeout_count = bank[REG_FASTLOCK][FASTLOCK_TIMEOUT_COUNT_LSB +: FASTLOCK_TIMEOUT_COUNT_W];
  wire next_cal = main_hit & ~frame.data[CAL_SKIP_BIT];
  wire next_fl = main_hit & (fastlock_timeout_count != '0);

  // Edge history registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      // Idle pin levels, so no false strobe edge follows reset
      sclk_d <= PIN_IDLE[0];
      strobe_d <= PIN_IDLE[2];
    end else begin
      sclk_d <= sclk_s;
      strobe_d <= strobe_s;
    end
  end

  // Shift register; older bits fall off the top, keeping the last 32
  // A short frame commits whatever the register still holds
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      shreg <= '0;
    end else if (shift_en) begin
      shreg <= {shreg[FRAME_W-2:0], data_s};
    end
  end

  // Register bank; soft reset is one cycle, well under the limit
  // Soft reset stores nothing, so its own bit reads back zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || srst_hit) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        bank[i] <= REG_DEFAULT;
      end
    end else if (commit) begin
      bank[frame.addr] <= frame.data;
    end
  end

  // Trigger pulses, registered
  // Each pulse lasts one cycle; the analog side counts edges
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_cal_start <= 1'b0;
      o_fastlock_start <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      o_cal_start <= next_cal;
      o_fastlock_start <= next_fl;
      o_soft_reset <= srst_hit;
    end
  end

  // Bus decode; one wait cycle for every access
  // Bank is read only; writes reach only control and status
  wire bus_req = i_avs_read | i_avs_write;
  wire in_bank = i_avs_address <= OFS_BANK_TOP;
  wire hit_ctrl = i_avs_address == OFS_CTRL;
  wire hit_stat = i_avs_address == OFS_STAT;
  wire bus_wr = i_avs_write & ack;
  wire [ADDR_W-1:0] bank_idx = i_avs_address[ADDR_W+1:2];
  wire [ST_W-1:0] stat_clr = (bus_wr && hit_stat) ? i_avs_writedata[ST_W-1:0] : '0;
  wire [ST_W-1:0] stat_set = {commit, srst_hit, next_fl, next_cal};
  wire [31:0] next_rdata = in_bank ? {4'h0, bank[bank_idx]} :
                           hit_ctrl ? ctrl :
                           hit_stat ? {28'h0000000, stat} : 32'h00000000;
  assign o_avs_waitrequest = bus_req & ~ack;

  // Answer phase and read data capture
  // Read data captured every cycle; it stands when waitrequest drops
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ack <= 1'b0;
      o_avs_readdata <= '0;
    end else begin
      ack <= bus_req & ~ack;
      o_avs_readdata <= next_rdata;
    end
  end

  // Control and sticky status; a set beats a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
      stat <= ST_RESET;
    end else begin
      if (bus_wr && hit_ctrl) begin
        ctrl <= i_avs_writedata;
      end
      stat <= (stat & ~stat_clr) | stat_set;
    end
  end

  // Helper copies of the frame as it stood one cycle earlier, taken every cycle, for checking
  logic [ADDR_W-1:0] last_addr;
  logic [DATA_W-1:0] last_data;
  always_ff @(posedge i_ref_clk) begin
    last_addr <= frame.addr;
    last_data <= frame.data;
  end

  // Checks share the reference clock; reset masks every attempt
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Serial shift: the new bit enters at the bottom
  a_shift_msb_first: assert property (shift_en |=>
    shreg[0] == $past(data_s) && shreg[FRAME_W-1:1] == $past(shreg[FRAME_W-2:0]))
    else $error("shift register did not take data at the bottom");
  // Oldest bit falls off the top, so the last 32 bits stay
  a_keep_last_bits: assert property (shift_en |=>
    shreg[FRAME_W-1] == $past(shreg[FRAME_W-2]))
    else $error("top bit of shift register not the next older bit");
  // Clock pulses under a high strobe leave everything alone
  a_strobe_high_hold: assert property (strobe_s |=> $stable(shreg))
    else $error("shift register changed while strobe high");
  a_held_no_write: assert property (strobe_s && strobe_d |=>
    $stable(bank[REG_MAIN]) && $stable(bank[REG_FASTLOCK]) && $stable(bank[REG_SYSTEM]))
    else $error("register changed while strobe held high");

  // Commit lands in the selected register only
  a_commit_data: assert property (commit && !srst_hit |=>
    bank[last_addr] == last_data)
    else $error("committed data not in selected register");
  a_commit_select: assert property (commit && !srst_hit && frame.addr != REG_MAIN |=>
    bank[REG_MAIN] == $past(bank[REG_MAIN]))
    else $error("register 0 changed by a frame for another register");

  // Soft reset: defaults, self-clearing bit, single pulse
  a_soft_reset_all: assert property (srst_hit |=>
    bank[REG_MAIN] == REG_DEFAULT && bank[REG_FASTLOCK] == REG_DEFAULT && o_soft_reset)
    else $error("soft reset did not restore defaults");
  a_srst_selfclear: assert property (srst_hit |=> !bank[REG_SYSTEM][SRST_BIT])
    else $error("soft reset bit stayed set");
  a_srst_one_pulse: assert property (o_soft_reset |=> !o_soft_reset)
    else $error("soft reset pulse longer than one cycle");

  // Trigger pulses of a register 0 write
  a_cal_starts: assert property (main_hit && !frame.data[CAL_SKIP_BIT] |=> o_cal_start)
    else $error("calibration not started");
  a_cal_skipped: assert property (main_hit && frame.data[CAL_SKIP_BIT] |=> !o_cal_start)
    else $error("calibration started despite skip");
  a_fastlock_eng: assert property (main_hit |=> o_fastlock_start == ($past(fastlock_timeout_count) != '0))
    else $error("fastlock engage wrong");
  a_no_stray_pulse: assert property (!main_hit |=> !o_cal_start && !o_fastlock_start)
    else $error("trigger pulse without register 0 write");

  // Bus answers after exactly one wait cycle
  a_bus_one_wait: assert property (bus_req && !ack |=> !o_avs_waitrequest)
    else $error("bus request not answered after one wait cycle");

  // Main scenarios seen in the bench
  c_frame_commit: cover property (commit);
  c_strobe_noise: cover property (sclk_rise && strobe_s);
  c_soft_reset: cover property (srst_hit);
  c_cal_and_fl: cover property (next_cal && next_fl);
  c_bus_read: cover property (i_avs_read && ack);
endmodule // twrp_port

// ### tb/twrp_host.sv
// Host model driving the three-wire programming link
`timescale 1ns/100ps
module twrp_host (
  input wire logic i_ref_clk,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_load_strobe
);
  import twrp_pkg::*;
  // Idle: strobe high, clock low
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_load_strobe = 1'b1;
  end
  // Half link period, 16 ref cycles = 80 ns
  task automatic half();
    repeat (16) @(posedge i_ref_clk);
  endtask
  // One bit: data set up while clock low, then a rising edge
  task automatic bit_out(input logic b);
    o_sdata <= b;
    half();
    o_sclk <= 1'b1;
    half();
    o_sclk <= 1'b0;
  endtask
  // Frame, optionally led by 8 junk bits that must fall out
  task automatic send(input twrp_frame_t f, input logic [7:0] junk, input logic lead);
    o_load_strobe <= 1'b0; // clock is low here
    half();
    if (lead)
      for (int i = 7; i >= 0; i--) bit_out(junk[i]);
    for (int i = 31; i >= 0; i--) bit_out(f[i]); // MSB first, address last
    half();
    o_load_strobe <= 1'b1;
    o_sdata <= ~o_sdata; // Released line: no stable level
    half();
  endtask
  // Strobe pulse with no clocks: commits what the shift register holds
  task automatic recommit();
    o_load_strobe <= 1'b0; // clock is low here
    half();
    o_load_strobe <= 1'b1;
    half();
  endtask
  // Clock pulses with the strobe held high
  task automatic noise(input int n);
    repeat (n) bit_out(~o_sdata);
    half();
  endtask
endmodule // twrp_host

// ### tb/tb_twrp_port.sv
// Self-checking bench for the three-wire programming port
`timescale 1ns/100ps
module tb_twrp_port;
  import twrp_pkg::*;
  logic clk = 1'b0; // Reference clock
  logic rst_n = 1'b0; // Synchronous reset, active low
  logic sclk, sdata, strobe; // Link pins from the host
  logic [BUS_AW-1:0] addr = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata, rd;
  logic wreq, cal, fl, srst;
  int bad_count = 0;
  int compares = 0;
  int n_cal = 0;
  int n_fl = 0;
  int n_srst = 0;
  localparam logic [3:0] ORD [13] = '{4'hf, 4'hd, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5,
    4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  always #2.5 clk = ~clk;
  twrp_port i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_sdata(sdata),
    .i_load_strobe(strobe), .i_avs_address(addr), .i_avs_read(read),
    .i_avs_write(write), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_cal_start(cal), .o_fastlock_start(fl),
    .o_soft_reset(srst));
  twrp_host i_host (.i_ref_clk(clk), .o_sclk(sclk), .o_sdata(sdata), .o_load_strobe(strobe));
  // Count trigger pulses, one per cycle high
  always @(posedge clk) begin
    n_cal <= n_cal + (cal === 1'b1);
    n_fl <= n_fl + (fl === 1'b1);
    n_srst <= n_srst + (srst === 1'b1);
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
      bad_count++;
    if (got !== exp)
      $display("BAD %0t expected %h got %h", $time, exp, got);
  endtask
  // Bus cycle held until waitrequest is sampled low at a rising edge
  task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    read <= ~w;
    write <= w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rd = rdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] exp);
    avs(1'b0, a, 32'h0);
    chk(exp, rd);
  endtask
  task automatic frm(input logic [3:0] a, input logic [27:0] d);
    i_host.send({d, a}, 8'h00, 1'b0);
  endtask
  // Power-on order, then triggers of the final main write
  task automatic t_init();
    frm(REG_SYSTEM, 28'h1);
    chk(32'd1, n_srst);
    for (int i = 0; i < 13; i++) frm(ORD[i], {4'h0, ORD[i], 20'h0});
    chk(32'd1, n_cal);
    chk(32'd1, n_fl);
    rdr(8'h3c, 32'h00f00000);
    rdr(8'h10, 32'h00400000);
    $display("t_init done");
  endtask
  // Skip set: fastlock only, then clocks under a high strobe
  task automatic t_skip();
    frm(REG_MAIN, 28'h0020000); // Settle wait shortened, no analog lock
    chk(32'd1, n_cal);
    chk(32'd2, n_fl);
    i_host.noise(8);
    i_host.recommit(); // Shifted noise would change the address
    chk(32'd3, n_fl);
    chk(32'd1, n_cal);
    rdr(8'h00, 32'h00020000);
    $display("t_skip done");
  endtask
  // Excess bits, then bus refusals
  task automatic t_bus();
    i_host.send({28'h1234567, 4'h3}, 8'hff, 1'b1);
    rdr(8'h0c, 32'h01234567);
    rdr(8'h80, 32'h0);
    avs(1'b1, 8'h08, 32'hffffffff);
    rdr(8'h08, 32'h00200000);
    rdr(OFS_CTRL, CTRL_RESET);
    rdr(OFS_STAT, 32'h0000000f);
    avs(1'b1, OFS_STAT, 32'h0000000f);
    rdr(OFS_STAT, 32'h00000000);
    avs(1'b1, OFS_CTRL, 32'h00000000);
    frm(4'h2, 28'h0abcdef); // Port disabled: strobe rise ignored
    rdr(8'h08, 32'h00200000);
    rdr(OFS_STAT, 32'h00000000);
    avs(1'b1, OFS_CTRL, CTRL_RESET);
    $display("t_bus done");
  endtask
  // Soft reset returns the bank to defaults
  task automatic t_reset();
    frm(REG_SYSTEM, 28'h1);
    chk(32'd2, n_srst);
    rdr(8'h3c, {4'h0, REG_DEFAULT});
    rdr(8'h14, 32'h0);
    $display("t_reset done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_init();
    t_skip();
    t_bus();
    t_reset();
    report_and_stop();
  end
  // Watchdog, about three times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    $display("BAD %0t watchdog ran out", $time);
    bad_count++;
    report_and_stop();
  end
endmodule // tb_twrp_port
